// ==== logic/trfs_defines.svh ====
/*
  constants of the frame sync block: field lengths, correlation limits,
  robust format coding and default sync patterns.
  assumes it is included by bare name from the package and the modules.
*/
`ifndef TRFS_DEFINES_SVH
`define TRFS_DEFINES_SVH

`define TRFS_SYNC_LEN      64            // bits in either sync pattern
`define TRFS_SYNC_ERR_MAX  13            // most disagreeing bits still accepted
`define TRFS_WORD_LEN      16            // bits in one word-count word
`define TRFS_WORD_LOG2     4             // log2 of the word length
`define TRFS_BCH_N         15            // robust format codeword length
`define TRFS_BCH_K         7             // robust format message length
`define TRFS_BCH_POLY      8'hD1         // generator x^8+x^7+x^6+x^4+1, top term implied
`define TRFS_FMT_REPS      5             // copies of the codeword sent
`define TRFS_FMT_VOTE      3             // copies that must agree
`define TRFS_FMT_LEN       75            // reps times codeword length
`define TRFS_NORMAL_SYNC   64'hA5C3_96F0_1E78_4B2D  // arbitrary default
`define TRFS_ROBUST_SYNC   64'h3C5A_E187_D24B_0F69  // arbitrary default
`define TRFS_PREAMBLE_BIT  1'h1          // level sent in the crypto preamble
`define TRFS_POSTAMBLE_BIT 1'h0          // level sent in the crypto postamble

`endif

// ==== logic/trfs_pkg.sv ====
/*
  types of the frame sync block: transmit and receive state enumerations.
  assumes trfs_defines.svh is on the include path.
*/
package trfs_pkg;
  `include "trfs_defines.svh"

  // transmit fields in the order they leave the terminal
  typedef enum logic [3:0] {
    TX_IDLE, TX_PRE, TX_PHASE, TX_SYNC, TX_FMT, TX_TWC, TX_DATA, TX_PAD, TX_POST
  } trfs_tx_state_type;

  // receive search and processing phases
  typedef enum logic [1:0] {
    RX_SEARCH, RX_FMT, RX_DATA
  } trfs_rx_state_type;
endpackage : trfs_pkg

// ==== logic/trfs_correlator.sv ====
/*
  sync pattern correlator: compares a 64-bit window with the normal and robust
  patterns, true and inverted, and reports a match within the error limit.
  assumes the window is presented on the cycle its newest bit arrives.
*/
`include "trfs_defines.svh"
module trfs_correlator
  import trfs_pkg::*;
#(
  parameter logic [63:0] NORMAL_SYNC = `TRFS_NORMAL_SYNC,
  parameter logic [63:0] ROBUST_SYNC = `TRFS_ROBUST_SYNC,
  parameter int          ERR_MAX     = `TRFS_SYNC_ERR_MAX
)(
  input  wire logic [63:0] i_window,    // newest bit in bit 0
  output logic             o_hit,       // either pattern found
  output logic             o_robust,    // robust pattern found
  output logic             o_inverted   // match was on inverted data
);
  // count of set bits, used for both patterns
  function automatic logic [6:0] pop64(input logic [63:0] v);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 0; i < 64; i++)
    begin
      c = c + {6'h00, v[i]};
    end
    return c;
  endfunction : pop64

  logic [6:0] err_n;  // disagreements with the normal pattern
  logic [6:0] err_r;  // disagreements with the robust pattern
  logic       n_true; // normal, true polarity
  logic       n_inv;  // normal, inverted polarity
  logic       r_true; // robust, true polarity
  logic       r_inv;  // robust, inverted polarity

  // inverted data disagrees exactly where true data agrees
  always_comb
  begin
    err_n  = pop64(i_window ^ NORMAL_SYNC);
    err_r  = pop64(i_window ^ ROBUST_SYNC);
    n_true = err_n <= 7'(ERR_MAX);
    n_inv  = err_n >= 7'(`TRFS_SYNC_LEN - ERR_MAX);
    r_true = err_r <= 7'(ERR_MAX);
    r_inv  = err_r >= 7'(`TRFS_SYNC_LEN - ERR_MAX);
    // robust wins a tie, so its format field is not skipped
    o_robust   = r_true | r_inv;
    o_hit      = o_robust | n_true | n_inv;
    o_inverted = o_robust ? (r_inv & ~r_true) : (n_inv & ~n_true);
  end
endmodule : trfs_correlator

// ==== logic/trfs_frame_sync.sv ====
/*
  frame builder and frame synchronizer for a bit-serial radio link.
  transmit: preamble, phasing, sync, robust format, word count, data, pad,
  postamble. receive: sync search, inversion, robust format vote, data out.
  assumes one bit per clock at most, inputs synchronous to i_clk.
*/
`include "trfs_defines.svh"
module trfs_frame_sync
  import trfs_pkg::*;
#(
  parameter logic [63:0] NORMAL_SYNC = `TRFS_NORMAL_SYNC,
  parameter logic [63:0] ROBUST_SYNC = `TRFS_ROBUST_SYNC,
  parameter int          ERR_MAX     = `TRFS_SYNC_ERR_MAX
)(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_tx_start,        // pulse: begin a transmission
  input  wire logic        i_tx_crypto_en,    // add preamble and postamble
  input  wire logic        i_tx_packet_mode,  // packet interface, no phasing
  input  wire logic        i_tx_robust,       // send robust sync and format
  input  wire logic [6:0]  i_tx_format,       // robust format message
  input  wire logic [15:0] i_tx_pre_len,      // preamble bits
  input  wire logic [15:0] i_tx_phase_len,    // phasing bits
  input  wire logic [15:0] i_tx_post_len,     // postamble bits
  input  wire logic [15:0] i_tx_data_bits,    // data field bits
  input  wire logic        i_tx_data_valid,   // data bit offered
  input  wire logic        i_tx_data_bit,     // data bit value
  output logic             o_tx_data_ready,   // data bit taken when valid
  output logic             o_tx_bit,          // line bit
  output logic             o_tx_valid,        // line bit strobe
  output logic             o_tx_fec_bypass,   // bit is pad, skip fec and dispersion
  output logic             o_tx_active,       // transmission in progress
  input  wire logic        i_rx_valid,        // line bit strobe
  input  wire logic        i_rx_bit,          // line bit value
  input  wire logic        i_rx_end,          // transmission ended
  output logic             o_rx_sync,         // pulse: sync found
  output logic             o_rx_robust,       // robust pattern found
  output logic             o_rx_inverted,     // data is inverted on the line
  output logic [6:0]       o_rx_format,       // voted format message
  output logic             o_rx_format_valid, // pulse: format ready
  output logic             o_rx_bit,          // corrected data bit
  output logic             o_rx_bit_valid     // data bit strobe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // systematic bch(15,7) codeword, message in the top seven bits
  function automatic logic [14:0] bch_enc(input logic [6:0] m);
    logic [7:0] r;
    logic       fb;
    r = 8'h00;
    for (int i = 6; i >= 0; i--)
    begin
      fb = m[i] ^ r[7];
      r  = {r[6:0], 1'h0} ^ (fb ? `TRFS_BCH_POLY : 8'h00);
    end
    return {m, r};
  endfunction : bch_enc

  // per codeword bit, three of five copies decide
  function automatic logic [14:0] vote(input logic [74:0] v);
    logic [14:0] o;
    logic [2:0]  c;
    o = 15'h0000;
    for (int b = 0; b < `TRFS_BCH_N; b++)
    begin
      c = 3'h0;
      for (int k = 0; k < `TRFS_FMT_REPS; k++)
      begin
        c = c + {2'h0, v[b + `TRFS_BCH_N * k]};
      end
      o[b] = c >= 3'(`TRFS_FMT_VOTE);
    end
    return o;
  endfunction : vote

  trfs_tx_state_type tx_state;     // current transmit field
  trfs_tx_state_type first_field;  // first field with bits after start
  trfs_tx_state_type after_field;  // field following the current one
  logic [15:0]       cnt;          // bit index within field
  logic [15:0]       flen [9];     // length of each field
  logic              cfg_crypto;   // latched options
  logic              cfg_packet;
  logic              cfg_robust;
  logic [15:0]       cfg_pre;
  logic [15:0]       cfg_phase;
  logic [15:0]       cfg_post;
  logic [15:0]       cfg_data;
  logic [74:0]       fmt_rep;      // five codeword copies, first at top
  logic [15:0]       transmission_word_count;          // transmission word count
  logic              emit;         // a bit leaves this cycle
  logic              cur_bit;      // value of that bit
  trfs_tx_state_type field_q;      // field of the bit on o_tx_bit
  logic [15:0]       idx_q;        // index of the bit on o_tx_bit
  logic [3:0]        word_pos;     // data plus pad bits mod word

  // field lengths; while idle they follow the inputs so start can skip ahead
  always_comb
  begin
    logic        cr;
    logic        pk;
    logic [15:0] db;
    cr = (tx_state == TX_IDLE) ? i_tx_crypto_en   : cfg_crypto;
    pk = (tx_state == TX_IDLE) ? i_tx_packet_mode : cfg_packet;
    db = (tx_state == TX_IDLE) ? i_tx_data_bits   : cfg_data;
    flen[0] = 16'h0000;
    flen[1] = cr ? ((tx_state == TX_IDLE) ? i_tx_pre_len : cfg_pre) : 16'h0000;
    flen[2] = pk ? 16'h0000 : ((tx_state == TX_IDLE) ? i_tx_phase_len : cfg_phase);
    flen[3] = 16'(`TRFS_SYNC_LEN);
    flen[4] = ((tx_state == TX_IDLE) ? i_tx_robust : cfg_robust) ?
              16'(`TRFS_FMT_LEN) : 16'h0000;
    flen[5] = 16'(`TRFS_WORD_LEN);
    flen[6] = db;
    flen[7] = {12'h000, 4'(16'(`TRFS_WORD_LEN) - {12'h000, db[3:0]})};
    flen[8] = cr ? ((tx_state == TX_IDLE) ? i_tx_post_len : cfg_post) : 16'h0000;
    // walk past empty fields; post wraps to idle
    first_field = TX_PRE;
    after_field = (tx_state == TX_POST) ? TX_IDLE : trfs_tx_state_type'(tx_state + 4'h1);
    for (int k = 0; k < 8; k++)
    begin
      if (first_field != TX_IDLE && flen[first_field] == 16'h0000)
        first_field = (first_field == TX_POST) ? TX_IDLE :
                      trfs_tx_state_type'(first_field + 4'h1);
      if (after_field != TX_IDLE && flen[after_field] == 16'h0000)
        after_field = (after_field == TX_POST) ? TX_IDLE :
                      trfs_tx_state_type'(after_field + 4'h1);
    end
  end

  // word count: one word for itself plus data rounded up
  assign transmission_word_count     = 16'h0001 + {4'h0, cfg_data[15:4]} + {15'h0000, |cfg_data[3:0]};
  assign fmt_rep = {`TRFS_FMT_REPS{bch_enc(i_tx_format)}};
  assign emit    = (tx_state != TX_IDLE) && (tx_state != TX_DATA || i_tx_data_valid);
  assign o_tx_data_ready = (tx_state == TX_DATA);

  // bit value of the current field position
  always_comb
  begin
    case (tx_state)
      TX_PRE:   cur_bit = `TRFS_PREAMBLE_BIT;
      TX_PHASE: cur_bit = ~cnt[0];
      TX_SYNC:  cur_bit = cfg_robust ? ROBUST_SYNC[6'(63 - cnt)]
                                     : NORMAL_SYNC[6'(63 - cnt)];
      TX_FMT:   cur_bit = fmt_rep[7'(74 - cnt)];
      TX_TWC:   cur_bit = transmission_word_count[4'(15 - cnt)];
      TX_DATA:  cur_bit = i_tx_data_bit;
      TX_PAD:   cur_bit = 1'h0;
      TX_POST:  cur_bit = `TRFS_POSTAMBLE_BIT;
      default:  cur_bit = 1'h0;
    endcase
  end

  // transmit sequencer; options latched at start stay fixed for the frame
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      tx_state   <= TX_IDLE;
      cnt        <= 16'h0000;
      cfg_crypto <= 1'h0;
      cfg_packet <= 1'h0;
      cfg_robust <= 1'h0;
      cfg_pre    <= 16'h0000;
      cfg_phase  <= 16'h0000;
      cfg_post   <= 16'h0000;
      cfg_data   <= 16'h0000;
    end
    else if (tx_state == TX_IDLE)
    begin
      if (i_tx_start)
      begin
        tx_state   <= first_field;
        cnt        <= 16'h0000;
        cfg_crypto <= i_tx_crypto_en;
        cfg_packet <= i_tx_packet_mode;
        cfg_robust <= i_tx_robust;
        cfg_pre    <= i_tx_pre_len;
        cfg_phase  <= i_tx_phase_len;
        cfg_post   <= i_tx_post_len;
        cfg_data   <= i_tx_data_bits;
      end
    end
    else if (emit)
    begin
      if (cnt == flen[tx_state] - 16'h0001)
      begin
        tx_state <= after_field;
        cnt      <= 16'h0000;
      end
      else
        cnt <= cnt + 16'h0001;
    end
  end

  // line outputs registered one cycle behind the sequencer
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_tx_bit        <= 1'h0;
      o_tx_valid      <= 1'h0;
      o_tx_fec_bypass <= 1'h0;
      o_tx_active     <= 1'h0;
      field_q         <= TX_IDLE;
      idx_q           <= 16'h0000;
    end
    else
    begin
      o_tx_bit        <= emit & cur_bit;
      o_tx_valid      <= emit;
      o_tx_fec_bypass <= emit && tx_state == TX_PAD;
      o_tx_active     <= tx_state != TX_IDLE;
      field_q         <= tx_state;
      idx_q           <= cnt;
    end
  end

  // helper for checks: position within the word across data and pad
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || field_q == TX_TWC)
      word_pos <= 4'h0;
    else if (o_tx_valid && (field_q == TX_DATA || field_q == TX_PAD))
      word_pos <= word_pos + 4'h1;
  end

  trfs_rx_state_type rx_state;  // receive phase
  logic [63:0]       shreg;     // raw line history
  logic [74:0]       fmt_sh;    // corrected format bits
  logic [6:0]        fmt_cnt;   // format bits gathered
  logic              c_hit;     // correlator results
  logic              c_robust;
  logic              c_inv;
  logic [14:0]       fmt_voted; // vote over the five copies, last bit included

  // a function result cannot be part-selected, so the vote lands in a net first
  assign fmt_voted = vote({fmt_sh[73:0], i_rx_bit ^ o_rx_inverted});

  trfs_correlator #(
    .NORMAL_SYNC (NORMAL_SYNC),
    .ROBUST_SYNC (ROBUST_SYNC),
    .ERR_MAX     (ERR_MAX)
  ) u_corr (
    .i_window   ({shreg[62:0], i_rx_bit}),
    .o_hit      (c_hit),
    .o_robust   (c_robust),
    .o_inverted (c_inv)
  );

  // raw history always shifts so the window is full at search time
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      shreg <= 64'h0000_0000_0000_0000;
    else if (i_rx_valid)
      shreg <= {shreg[62:0], i_rx_bit};
  end

  // receive sequencer; end of transmission takes priority everywhere
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      rx_state          <= RX_SEARCH;
      o_rx_sync         <= 1'h0;
      o_rx_robust       <= 1'h0;
      o_rx_inverted     <= 1'h0;
      o_rx_format       <= 7'h00;
      o_rx_format_valid <= 1'h0;
      o_rx_bit          <= 1'h0;
      o_rx_bit_valid    <= 1'h0;
      fmt_sh            <= 75'h0;
      fmt_cnt           <= 7'h00;
    end
    else
    begin
      o_rx_sync         <= 1'h0;
      o_rx_format_valid <= 1'h0;
      o_rx_bit_valid    <= 1'h0;
      if (i_rx_end)
      begin
        rx_state      <= RX_SEARCH;
        o_rx_robust   <= 1'h0;
        o_rx_inverted <= 1'h0;
      end
      else
        case (rx_state)
          RX_SEARCH:
            if (i_rx_valid && c_hit)
            begin
              rx_state      <= c_robust ? RX_FMT : RX_DATA;
              o_rx_sync     <= 1'h1;
              o_rx_robust   <= c_robust;
              o_rx_inverted <= c_inv;
              fmt_cnt       <= 7'h00;
            end
          RX_FMT:
            if (i_rx_valid)
            begin
              fmt_sh  <= {fmt_sh[73:0], i_rx_bit ^ o_rx_inverted};
              fmt_cnt <= fmt_cnt + 7'h01;
              if (fmt_cnt == 7'(`TRFS_FMT_LEN - 1))
              begin
                o_rx_format       <= fmt_voted[14:8];
                o_rx_format_valid <= 1'h1;
                rx_state          <= RX_DATA;
              end
            end
          default:
          begin
            o_rx_bit       <= i_rx_bit ^ o_rx_inverted;
            o_rx_bit_valid <= i_rx_valid;
          end
        endcase
    end
  end

  property p_phase_alt;
    o_tx_valid && field_q == TX_PHASE |-> o_tx_bit == ~idx_q[0];
  endproperty
  a_phase_alt: assert property (p_phase_alt) else $error("phasing bit wrong");

  property p_packet_nophase;
    tx_state == TX_PHASE |-> !cfg_packet;
  endproperty
  a_packet_nophase: assert property (p_packet_nophase) else $error("phasing in packet");

  property p_sync_pattern;
    o_tx_valid && field_q == TX_SYNC |->
      o_tx_bit == (cfg_robust ? ROBUST_SYNC[6'(63 - idx_q)] : NORMAL_SYNC[6'(63 - idx_q)]);
  endproperty
  a_sync_pattern: assert property (p_sync_pattern) else $error("sync bit wrong");

  property p_pad_whole;
    field_q == TX_PAD ##1 field_q != TX_PAD |-> word_pos == 4'h0;
  endproperty
  a_pad_whole: assert property (p_pad_whole) else $error("pad not word aligned");

  property p_pad_bypass;
    o_tx_valid && field_q == TX_PAD |-> o_tx_fec_bypass && !o_tx_bit;
  endproperty
  a_pad_bypass: assert property (p_pad_bypass) else $error("pad bit not bypassed");

  property p_detect;
    rx_state == RX_SEARCH && !i_rx_end && i_rx_valid && c_hit |=>
      o_rx_sync && rx_state != RX_SEARCH && o_rx_inverted == $past(c_inv);
  endproperty
  a_detect: assert property (p_detect) else $error("sync missed");

  property p_normal_first;
    rx_state == RX_SEARCH && !i_rx_end && i_rx_valid && c_hit && !c_robust |=>
      rx_state == RX_DATA && !o_rx_robust;
  endproperty
  a_normal_first: assert property (p_normal_first) else $error("robust after normal");

  property p_invert;
    rx_state == RX_DATA && o_rx_inverted && !i_rx_end && i_rx_valid |=>
      o_rx_bit_valid && o_rx_bit == !$past(i_rx_bit);
  endproperty
  a_invert: assert property (p_invert) else $error("inverted bit not corrected");

  property p_hold;
    rx_state != RX_SEARCH && !i_rx_end |=> rx_state != RX_SEARCH && !o_rx_sync;
  endproperty
  a_hold: assert property (p_hold) else $error("search resumed early");
endmodule : trfs_frame_sync

// ==== testbench/trfs_radio_model.sv ====
/*
  radio loopback model: hands each line bit back to the receiver one cycle
  later, optionally inverted and with chosen bits of the frame in error.
  assumes the line strobe marks every transmitted bit of a frame.
*/
module trfs_radio_model
(
  input  wire logic        i_clk,       // bit clock
  input  wire logic        i_tx_bit,    // line bit from the terminal
  input  wire logic        i_tx_valid,  // line bit strobe
  input  wire logic        i_tx_active, // frame in progress
  input  wire logic        i_invert,    // radio path inverts the data
  input  wire logic [15:0] i_err_base,  // line bit index of mask bit 0
  input  wire logic [63:0] i_err_mask,  // bits corrupted from the base on
  output logic             o_rx_bit,    // bit handed to the receiver
  output logic             o_rx_valid   // receive strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cnt;  // line bits sent in this frame
  logic [15:0] ofs;  // position relative to the error window
  logic        flip; // this bit goes out corrupted
  assign ofs  = cnt - i_err_base;
  assign flip = (cnt >= i_err_base) && (ofs < 16'h0040) && i_err_mask[ofs[5:0]];
  // count line bits, restarting between frames
  always @(posedge i_clk)
  begin
    if (!i_tx_active && !i_tx_valid)
      cnt <= 16'h0000;
    else if (i_tx_valid)
      cnt <= cnt + 16'h0001;
  end
  // echo one cycle later; between bits the line toggles so no stale level looks valid
  always @(posedge i_clk)
  begin
    o_rx_valid <= i_tx_valid;
    if (i_tx_valid)
      o_rx_bit <= i_tx_bit ^ i_invert ^ flip;
    else
      o_rx_bit <= ~o_rx_bit;
  end
endmodule : trfs_radio_model

// ==== testbench/tb_top.sv ====
/*
  self-checking bench of the frame sync block: notes every expected line and
  receive bit, loops the line through the radio model and compares.
  assumes the package and its defines header are compiled first.
*/
`include "trfs_defines.svh"
module tb_top
  import trfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [63:0] NSYNC = 64'h96E2_3B7D_C418_5FA0; // arbitrary normal pattern
  localparam logic [63:0] RSYNC = 64'h1F6B_A43C_87D9_25E0; // arbitrary robust pattern
  logic        i_clk = 1'b0, i_rst_n = 1'b0, i_tx_start = 1'b0, i_rx_end = 1'b0;
  logic        i_tx_crypto_en = 1'b0, i_tx_packet_mode = 1'b0, i_tx_robust = 1'b0;
  logic        i_tx_data_valid = 1'b0, i_tx_data_bit = 1'b0;
  logic [6:0]  i_tx_format = 7'h00;
  logic [15:0] i_tx_pre_len = 16'h0, i_tx_phase_len = 16'h0, i_tx_post_len = 16'h0;
  logic [15:0] i_tx_data_bits = 16'h0;
  logic        i_rx_valid, i_rx_bit, o_tx_data_ready, o_tx_bit, o_tx_valid;
  logic        o_tx_fec_bypass, o_tx_active, o_rx_sync, o_rx_robust, o_rx_inverted;
  logic        o_rx_format_valid, o_rx_bit, o_rx_bit_valid;
  logic [6:0]  o_rx_format;
  logic [31:0] seed = 32'h8BF1;   // stimulus generator state
  logic [1:0]  txq[$];            // expected line bits {bypass, bit}
  logic        rxq[$];            // expected corrected receive bits
  logic        dbits[256];        // data field of the current frame
  int          didx = 0;          // next data bit to offer
  int          syncs, fvs;        // detections and format pulses seen
  logic [6:0]  exp_fmt = 7'h00;   // format message in flight
  logic        inv = 1'b0;        // radio inverts the line
  logic [15:0] ebase = 16'h0;     // line bit of mask bit 0
  logic [63:0] emask = 64'h0;     // corruption pattern
  int          checked = 0, miscompares = 0;

  trfs_frame_sync #(.NORMAL_SYNC(NSYNC), .ROBUST_SYNC(RSYNC), .ERR_MAX(13)) DUT (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_tx_start(i_tx_start),
    .i_tx_crypto_en(i_tx_crypto_en), .i_tx_packet_mode(i_tx_packet_mode),
    .i_tx_robust(i_tx_robust), .i_tx_format(i_tx_format), .i_tx_pre_len(i_tx_pre_len),
    .i_tx_phase_len(i_tx_phase_len), .i_tx_post_len(i_tx_post_len),
    .i_tx_data_bits(i_tx_data_bits), .i_tx_data_valid(i_tx_data_valid),
    .i_tx_data_bit(i_tx_data_bit), .o_tx_data_ready(o_tx_data_ready), .o_tx_bit(o_tx_bit),
    .o_tx_valid(o_tx_valid), .o_tx_fec_bypass(o_tx_fec_bypass), .o_tx_active(o_tx_active),
    .i_rx_valid(i_rx_valid), .i_rx_bit(i_rx_bit), .i_rx_end(i_rx_end), .o_rx_sync(o_rx_sync),
    .o_rx_robust(o_rx_robust), .o_rx_inverted(o_rx_inverted), .o_rx_format(o_rx_format),
    .o_rx_format_valid(o_rx_format_valid), .o_rx_bit(o_rx_bit),
    .o_rx_bit_valid(o_rx_bit_valid));

  trfs_radio_model radio (
    .i_clk(i_clk), .i_tx_bit(o_tx_bit), .i_tx_valid(o_tx_valid), .i_tx_active(o_tx_active),
    .i_invert(inv), .i_err_base(ebase), .i_err_mask(emask), .o_rx_bit(i_rx_bit),
    .o_rx_valid(i_rx_valid));

  always #20 i_clk = ~i_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // mask with exactly n corrupted bits at random places
  function automatic logic [63:0] mk(input int n);
    logic [63:0] m;
    m = 64'h0;
    while ($countones(m) < n)
    begin
      m[seed[5:0]] = 1'b1;
      seed = lfsr(seed);
    end
    return m;
  endfunction : mk

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic close_out();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  // one frame: note the line, drive the start, then check the receive summary
  task automatic frame(input logic cr, pk, rb, input int pre, ph, post, n,
                       input logic iv, input int eoff, input logic [63:0] m, input logic dup);
    int          s, k;
    logic [15:0] wc;
    logic [7:0]  r;
    logic [14:0] cw;
    logic        es;
    es = (eoff != 0) || ($countones(m) <= 13);
    exp_fmt = seed[6:0];
    r = 8'h00;
    for (int i = 6; i >= 0; i--)
      r = {r[6:0], 1'b0} ^ (((exp_fmt[i] ^ r[7]) != 1'b0) ? `TRFS_BCH_POLY : 8'h00);
    if (cr) repeat (pre) txq.push_back(2'b01);
    if (!pk) for (int i = 0; i < ph; i++) txq.push_back({1'b0, ~i[0]});
    s = txq.size();
    for (int i = 63; i >= 0; i--) txq.push_back({1'b0, rb ? RSYNC[i] : NSYNC[i]});
    cw = {exp_fmt, r};
    if (rb) repeat (5) for (int i = 14; i >= 0; i--) txq.push_back({1'b0, cw[i]});
    wc = 16'(1 + (n + 15) / 16);
    for (int i = 15; i >= 0; i--) txq.push_back({1'b0, wc[i]});
    for (int i = 0; i < n; i++)
    begin
      dbits[i] = seed[9];
      seed = lfsr(seed);
      txq.push_back({1'b0, dbits[i]});
    end
    repeat ((16 - n % 16) % 16) txq.push_back(2'b10);
    if (cr) repeat (post) txq.push_back(2'b00);
    if (es) for (int i = s + (rb ? 139 : 64); i < txq.size(); i++) rxq.push_back(txq[i][0]);
    ebase = 16'(s + eoff);
    emask = m;
    inv = iv;
    syncs = 0;
    fvs = 0;
    @(negedge i_clk);
    {i_tx_crypto_en, i_tx_packet_mode, i_tx_robust, i_tx_format} = {cr, pk, rb, exp_fmt};
    {i_tx_pre_len, i_tx_phase_len, i_tx_post_len} = {16'(pre), 16'(ph), 16'(post)};
    i_tx_data_bits = 16'(n);
    i_tx_start = 1'b1;
    k = 0;
    do
    begin
      @(negedge i_clk);
      k++;
      i_tx_start = dup && (k == 40);
    end
    while ((o_tx_active || k < 4) && k < 3000);
    repeat (4) @(negedge i_clk);
    chk("sync count", 16'(syncs), 16'(es));
    chk("format count", 16'(fvs), 16'(es && rb));
    chk("robust flag", 16'(o_rx_robust), 16'(es && rb));
    chk("inverted flag", 16'(o_rx_inverted), 16'(es && iv));
    chk("bits left", 16'(txq.size() + rxq.size()), 16'h0000);
    i_rx_end = 1'b1;
    @(negedge i_clk);
    i_rx_end = 1'b0;
    @(negedge i_clk);
    chk("flags after end", 16'({o_rx_robust, o_rx_inverted}), 16'h0000);
  endtask : frame

  // data offers with random stalls; index moves only when a bit is taken
  always @(posedge i_clk)
    didx <= !o_tx_active ? 0 : didx + int'(o_tx_data_ready && i_tx_data_valid);
  always @(negedge i_clk)
  begin
    i_tx_data_valid = seed[4] | seed[7];
    i_tx_data_bit = dbits[didx];
    seed = lfsr(seed);
  end

  // compare each result against the oldest note as it appears
  always @(posedge i_clk)
  begin : watch
    logic [1:0] e;
    logic       b;
    if (i_rst_n)
    begin
      if (o_tx_valid)
      begin
        e = (txq.size() != 0) ? txq.pop_front() : 2'bXX;
        chk("line bit", 16'(o_tx_bit), 16'(e[0]));
        chk("pad bypass", 16'(o_tx_fec_bypass), 16'(e[1]));
      end
      if (o_rx_bit_valid)
      begin
        b = (rxq.size() != 0) ? rxq.pop_front() : 1'bX;
        chk("rx bit", 16'(o_rx_bit), 16'(b));
      end
      if (o_rx_format_valid)
      begin
        fvs++;
        chk("rx format", 16'(o_rx_format), 16'(exp_fmt));
      end
      if (o_rx_sync)
        syncs++;
    end
  end

  // watchdog: about a thousand cycles are expected, allow far more
  initial
  begin
    #800000;
    miscompares++;
    close_out();
  end

  initial
  begin
    repeat (10) @(negedge i_clk);
    chk("reset outputs", 16'({o_tx_valid, o_tx_active, o_rx_sync, o_tx_data_ready}), 16'h0);
    i_rst_n = 1'b1;
    // crypto, phasing, 13 sync errors still found, pad of 12
    frame(1'b1, 1'b0, 1'b0, 8, 7, 5, 20, 1'b0, 0, mk(13), 1'b0);
    // packet robust inverted, two format copies wrong, start while busy
    frame(1'b0, 1'b1, 1'b1, 0, 9, 0, 32, 1'b1, 64, (64'h7FFF << 15) | (64'h7FFF << 45), 1'b1);
    // 14 errors on inverted data must not be found, pad of 15
    frame(1'b0, 1'b0, 1'b0, 0, 4, 0, 1, 1'b1, 0, mk(14), 1'b0);
    repeat (3)
      frame(seed[0], seed[1], seed[2], int'(seed[5:3]), int'(seed[8:6]), int'(seed[11:9]),
            1 + int'(seed[16:12]), seed[17], 0, 64'h0, 1'b0);
    close_out();
  end
endmodule : tb_top
